// ==== hdl/asp_params.svh ====
// offsets, field positions, reset values and timing counts of the serial port
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
`define ASP_OFF_CTRL        12'h000
`define ASP_OFF_DATA        12'h004
`define ASP_OFF_POWER       12'h008
`define ASP_OFF_RELOAD      12'h00C
`define ASP_OFF_RATE        12'h010
`define ASP_CTRL_MODE_LOW   7
`define ASP_CTRL_FE         7
`define ASP_CTRL_MODE_HIGH  6
`define ASP_CTRL_MULTIPROC  5
`define ASP_CTRL_RX_ALLOW   4
`define ASP_CTRL_TX_NINTH   3
`define ASP_CTRL_RX_NINTH   2
`define ASP_CTRL_TX_DONE    1
`define ASP_CTRL_RX_DONE    0
`define ASP_PWR_FCHECK      6
`define ASP_PWR_DOUBLE      7
`define ASP_RATE_RUN        4
`define ASP_RATE_TX_SRC     3
`define ASP_RATE_RX_SRC     2
`define ASP_RATE_FAST       1
`define ASP_RATE_M0SRC      0
`define ASP_RST_BYTE        8'h00
`define ASP_PRESCALE        6
`define ASP_SMP_LAST        4'hF
`define ASP_SMP_VOTE_LO     4'h7
`define ASP_SMP_VOTE_HI     4'h9
`define ASP_SMP_DECIDE      4'hA
`define ASP_BITS_8          4'hA
`define ASP_BITS_9          4'hB
`endif

// ==== hdl/asp_pkg.sv ====
// types shared by the serial port modules
package asp_pkg;
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8VAR  = 2'b01,
    MODE_9FIX  = 2'b10,
    MODE_9VAR  = 2'b11
  } asp_mode_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'b0_0001,
    RX_START = 5'b0_0010,
    RX_DATA  = 5'b0_0100,
    RX_NINTH = 5'b0_1000,
    RX_STOP  = 5'b1_0000
  } asp_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } asp_tx_state_t;

  typedef struct packed {
    logic mode_low;
    logic mode_high;
    logic multiproc_enable;
    logic rx_allow;
    logic tx_ninth_bit;
  } asp_ctrl_t;
endpackage

// ==== hdl/asp_rate_gen.sv ====
// internal 8-bit auto-reload rate generator with optional divide-by-6 prescale
`timescale 1ns/1ns
`include "asp_params.svh"
module asp_rate_gen #(
  parameter int PRESCALE = `ASP_PRESCALE
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic       fast,
  input  wire logic [7:0] reload,
  output logic            ovf
);
  localparam int PW = $clog2(PRESCALE);
  logic [PW-1:0] pre_r;
  logic [7:0]    cnt_r;
  logic          step;

  // slow setting counts one peripheral clock in PRESCALE
  assign step = fast | (pre_r == PW'(PRESCALE - 1));

  // prescaler holds at zero while stopped so a restart begins cleanly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (!run || step) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PW'(1);
    end
  end

  // counter reloads on overflow; overflow is the rate pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= `ASP_RST_BYTE;
      ovf   <= 1'b0;
    end else begin
      ovf <= run & step & (cnt_r == 8'hFF);
      if (run && step) begin
        cnt_r <= (cnt_r == 8'hFF) ? reload : cnt_r + 8'h01;
      end
    end
  end
endmodule

// ==== hdl/asp_tick_div.sv ====
// turns rate pulses into 16x sample ticks, halving unless rate doubling is on
`timescale 1ns/1ns
module asp_tick_div (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic src,
  input  wire logic halve,
  output logic      tick
);
  logic ph_r;

  // phase toggles on every source pulse; even pulses pass when halving, the first is held back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r <= 1'b0;
    end else if (src) begin
      ph_r <= ~ph_r;
    end
  end

  assign tick = src & (~halve | ph_r);
endmodule

// ==== hdl/asp_serial_port.sv ====
// asynchronous serial port: apb registers, rate selection, transmitter and receiver
// Contract
// - 8-bit mode frame is start, eight data bits, stop: ten bits.
// - 8-bit mode stores received stop bit level in rx ninth-bit flag.
// - 9-bit modes frame: start, eight data lsb first, ninth bit, stop.
// - 9-bit modes store received ninth bit in rx ninth-bit flag.
// - 9-bit modes transmit the tx ninth-bit control as ninth bit.
// - transmit and receive run independently, full duplex.
// - writing the data buffer starts transmission of that byte; the code ignores the write in shift mode and while busy.
// - with receive allowed, a character starts only on a falling rxd edge.
// - framing check works in all async modes, only when enabled.
// - enabled check sets framing error when stop bit is low.
// - framing error stays set until software clear or reset.
// - with check enabled, receive done rises at the stop bit.
// - modes 1 and 3 pick timer 1 or generator per direction.
// - fixed 9-bit mode runs at pclk/32, or pclk/16 when doubled.
// - two mode bits select shift, 8-bit var, 9-bit fixed, 9-bit var.
// - transmit done set at start of stop bit, cleared by software.
// - generator is 8-bit auto-reload, pclk or pclk/6, gated by run.
// - timer 1 overflow forms the rate, rate double doubles it.
`timescale 1ns/1ns
`include "asp_params.svh"
module asp_serial_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer1_ovf,
  input  wire logic        rxd,
  output logic             txd
);
  asp_pkg::asp_ctrl_t     ctrl_r;
  asp_pkg::asp_mode_t     mode;
  asp_pkg::asp_rx_state_t rx_state_r;
  asp_pkg::asp_tx_state_t tx_state_r;
  logic        fe_r, rx_ninth_r, tdone_r, rdone_r, fcheck_r, rdouble_r;
  logic        run_r, txsrc_r, rxsrc_r, fast_r, m0src_r;
  logic [7:0]  reload_r, rx_buf_r, rx_sh_r;
  logic        rxd_meta_r, rxd_sync_r, rxd_prev_r;
  logic [3:0]  rx_smp_r, tx_smp_r, tx_cnt_r;
  logic [2:0]  rx_bitn_r;
  logic [1:0]  vote_r;
  logic [10:0] tx_sh_r;
  logic        acc, wr, hit, ctrl_wr, nine, async_on;
  logic        brg_ovf, rx_src, tx_src, rx_tick, tx_tick;
  logic        rx_fall, rx_bit, rx_decide, rx_done_set, rx_ninth_set, fe_set;
  logic        tx_load, tx_edge, tdone_set;
  logic [7:0]  ctrl_rd, rx_load_val;

  // ---- bus slave: zero wait states, error on unmapped address
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign hit     = (paddr == `ASP_OFF_CTRL) | (paddr == `ASP_OFF_DATA) | (paddr == `ASP_OFF_POWER)
                 | (paddr == `ASP_OFF_RELOAD) | (paddr == `ASP_OFF_RATE);
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign ctrl_wr = wr & (paddr == `ASP_OFF_CTRL);

  // bit 7 shows the framing error or the low mode bit, chosen by the check enable
  assign ctrl_rd = {fcheck_r ? fe_r : ctrl_r.mode_low, ctrl_r.mode_high, ctrl_r.multiproc_enable,
                    ctrl_r.rx_allow, ctrl_r.tx_ninth_bit, rx_ninth_r, tdone_r, rdone_r};

  // read data captured in the setup cycle so it is a flop at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `ASP_OFF_CTRL:   prdata <= {24'h00_0000, ctrl_rd};
        `ASP_OFF_DATA:   prdata <= {24'h00_0000, rx_buf_r};
        `ASP_OFF_POWER:  prdata <= {24'h00_0000, rdouble_r, fcheck_r, 6'h00};
        `ASP_OFF_RELOAD: prdata <= {24'h00_0000, reload_r};
        `ASP_OFF_RATE:   prdata <= {27'h000_0000, run_r, txsrc_r, rxsrc_r, fast_r, m0src_r};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // software configuration; the low mode bit is hidden behind the error flag when checking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
    end else if (ctrl_wr) begin
      if (!fcheck_r) begin
        ctrl_r.mode_low <= pwdata[`ASP_CTRL_MODE_LOW];
      end
      ctrl_r.mode_high        <= pwdata[`ASP_CTRL_MODE_HIGH];
      ctrl_r.multiproc_enable <= pwdata[`ASP_CTRL_MULTIPROC];
      ctrl_r.rx_allow         <= pwdata[`ASP_CTRL_RX_ALLOW];
      ctrl_r.tx_ninth_bit     <= pwdata[`ASP_CTRL_TX_NINTH];
    end
  end

  // power, reload and rate control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcheck_r  <= 1'b0;
      rdouble_r <= 1'b0;
      reload_r  <= `ASP_RST_BYTE;
      {run_r, txsrc_r, rxsrc_r, fast_r, m0src_r} <= 5'h00;
    end else if (wr) begin
      if (paddr == `ASP_OFF_POWER) begin
        fcheck_r  <= pwdata[`ASP_PWR_FCHECK];
        rdouble_r <= pwdata[`ASP_PWR_DOUBLE];
      end
      if (paddr == `ASP_OFF_RELOAD) begin
        reload_r <= pwdata[7:0];
      end
      if (paddr == `ASP_OFF_RATE) begin
        run_r   <= pwdata[`ASP_RATE_RUN];
        txsrc_r <= pwdata[`ASP_RATE_TX_SRC];
        rxsrc_r <= pwdata[`ASP_RATE_RX_SRC];
        fast_r  <= pwdata[`ASP_RATE_FAST];
        m0src_r <= pwdata[`ASP_RATE_M0SRC];
      end
    end
  end

  // hardware-set flags; a set in the same cycle as a software write wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fe_r       <= 1'b0;
      rx_ninth_r <= 1'b0;
      tdone_r    <= 1'b0;
      rdone_r    <= 1'b0;
    end else begin
      if (fe_set) begin
        fe_r <= 1'b1;
      end else if (ctrl_wr && fcheck_r) begin
        fe_r <= pwdata[`ASP_CTRL_FE];
      end
      if (rx_ninth_set) begin
        rx_ninth_r <= rx_bit;
      end else if (ctrl_wr) begin
        rx_ninth_r <= pwdata[`ASP_CTRL_RX_NINTH];
      end
      if (tdone_set) begin
        tdone_r <= 1'b1;
      end else if (ctrl_wr) begin
        tdone_r <= pwdata[`ASP_CTRL_TX_DONE];
      end
      if (rx_done_set) begin
        rdone_r <= 1'b1;
      end else if (ctrl_wr) begin
        rdone_r <= pwdata[`ASP_CTRL_RX_DONE];
      end
    end
  end

  // ---- rate selection
  assign mode     = asp_pkg::asp_mode_t'({ctrl_r.mode_low, ctrl_r.mode_high});
  assign async_on = (mode != asp_pkg::MODE_SHIFT);
  assign nine     = ctrl_r.mode_low;

  asp_rate_gen u_rate_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run_r),
    .fast    (fast_r),
    .reload  (reload_r),
    .ovf     (brg_ovf)
  );

  // fixed mode feeds every clock: 16 samples at pclk/2 gives pclk/32 per bit
  assign rx_src = (mode == asp_pkg::MODE_9FIX) ? 1'b1 : (rxsrc_r ? brg_ovf : timer1_ovf);
  assign tx_src = (mode == asp_pkg::MODE_9FIX) ? 1'b1 : (txsrc_r ? brg_ovf : timer1_ovf);

  asp_tick_div u_rx_div (
    .pclk    (pclk),
    .presetn (presetn),
    .src     (rx_src),
    .halve   (~rdouble_r),
    .tick    (rx_tick)
  );

  asp_tick_div u_tx_div (
    .pclk    (pclk),
    .presetn (presetn),
    .src     (tx_src),
    .halve   (~rdouble_r),
    .tick    (tx_tick)
  );

  // ---- transmitter
  assign tx_load   = wr & (paddr == `ASP_OFF_DATA) & async_on & (tx_state_r == asp_pkg::TX_IDLE);
  assign tx_edge   = tx_tick & (tx_smp_r == `ASP_SMP_LAST) & (tx_state_r == asp_pkg::TX_SHIFT);
  assign tdone_set = tx_edge & (tx_cnt_r == 4'h2);

  // frame shifts lsb first; a write while busy is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_r <= asp_pkg::TX_IDLE;
      tx_sh_r    <= 11'h7FF;
      tx_cnt_r   <= 4'h0;
      tx_smp_r   <= 4'h0;
      txd        <= 1'b1;
    end else if (tx_load) begin
      tx_state_r <= asp_pkg::TX_SHIFT;
      tx_sh_r    <= {1'b1, nine ? ctrl_r.tx_ninth_bit : 1'b1, pwdata[7:0], 1'b0};
      tx_cnt_r   <= nine ? `ASP_BITS_9 : `ASP_BITS_8;
      tx_smp_r   <= 4'h0;
      txd        <= 1'b0;
    end else if (tx_state_r == asp_pkg::TX_SHIFT) begin
      if (tx_tick) begin
        tx_smp_r <= tx_smp_r + 4'h1;
      end
      if (tx_edge) begin
        tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
        tx_cnt_r <= tx_cnt_r - 4'h1;
        txd      <= (tx_cnt_r == 4'h1) ? 1'b1 : tx_sh_r[1];
        if (tx_cnt_r == 4'h1) begin
          tx_state_r <= asp_pkg::TX_IDLE;
        end
      end
    end
  end

  // ---- receiver
  // two-flop synchroniser; edge detect looks only at the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_meta_r <= 1'b1;
      rxd_sync_r <= 1'b1;
      rxd_prev_r <= 1'b1;
    end else begin
      rxd_meta_r <= rxd;
      rxd_sync_r <= rxd_meta_r;
      rxd_prev_r <= rxd_sync_r;
    end
  end

  assign rx_fall   = rxd_prev_r & ~rxd_sync_r;
  assign rx_bit    = vote_r[1];                                   // two or three of three
  assign rx_decide = rx_tick & (rx_smp_r == `ASP_SMP_DECIDE) & (rx_state_r != asp_pkg::RX_IDLE);
  // without the check, done comes with the last data bit in 8-bit mode or the ninth bit in 9-bit modes, and skips the stop bit
  assign rx_done_set = rx_decide & (((rx_state_r == asp_pkg::RX_DATA) & (rx_bitn_r == 3'h7) & ~nine & ~fcheck_r)
                     | ((rx_state_r == asp_pkg::RX_NINTH) & ~fcheck_r)
                     | ((rx_state_r == asp_pkg::RX_STOP) & fcheck_r));
  assign rx_ninth_set = rx_decide & ((rx_state_r == asp_pkg::RX_NINTH)
                      | ((rx_state_r == asp_pkg::RX_STOP) & ~nine));
  assign fe_set      = rx_decide & (rx_state_r == asp_pkg::RX_STOP) & fcheck_r & ~rx_bit;
  assign rx_load_val = (rx_state_r == asp_pkg::RX_DATA) ? {rx_bit, rx_sh_r[7:1]} : rx_sh_r;

  // receive sequencer; stop handled at mid-bit so the next start edge is not missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_r <= asp_pkg::RX_IDLE;
      rx_smp_r   <= 4'h0;
      rx_bitn_r  <= 3'h0;
      vote_r     <= 2'h0;
      rx_sh_r    <= `ASP_RST_BYTE;
    end else begin
      case (rx_state_r)
        asp_pkg::RX_IDLE: begin
          rx_smp_r  <= 4'h0;
          vote_r    <= 2'h0;
          rx_bitn_r <= 3'h0;
          if (rx_fall && ctrl_r.rx_allow && async_on) begin
            rx_state_r <= asp_pkg::RX_START;
          end
        end
        default: begin
          if (rx_tick) begin
            rx_smp_r <= rx_smp_r + 4'h1;
            if (rx_smp_r >= `ASP_SMP_VOTE_LO && rx_smp_r <= `ASP_SMP_VOTE_HI) begin
              vote_r <= vote_r + {1'b0, rxd_sync_r};
            end
            if (rx_smp_r == `ASP_SMP_LAST) begin
              vote_r <= 2'h0;
            end
          end
          if (rx_decide) begin
            case (rx_state_r)
              asp_pkg::RX_START: begin
                if (rx_bit) begin
                  rx_state_r <= asp_pkg::RX_IDLE;
                end
              end
              asp_pkg::RX_DATA: begin
                rx_sh_r <= {rx_bit, rx_sh_r[7:1]};
              end
              asp_pkg::RX_STOP: begin
                rx_state_r <= asp_pkg::RX_IDLE;
              end
              default: begin
              end
            endcase
          end
          if (rx_tick && rx_smp_r == `ASP_SMP_LAST) begin
            case (rx_state_r)
              asp_pkg::RX_START: rx_state_r <= asp_pkg::RX_DATA;
              asp_pkg::RX_DATA: begin
                rx_bitn_r <= rx_bitn_r + 3'h1;
                if (rx_bitn_r == 3'h7) begin
                  rx_state_r <= nine ? asp_pkg::RX_NINTH : asp_pkg::RX_STOP;
                end
              end
              asp_pkg::RX_NINTH: rx_state_r <= asp_pkg::RX_STOP;
              default: rx_state_r <= rx_state_r;
            endcase
          end
        end
      endcase
    end
  end

  // receive half of the data buffer, separate from the transmit shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_r <= `ASP_RST_BYTE;
    end else if (rx_done_set) begin
      rx_buf_r <= rx_load_val;
    end
  end

  // ---- checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_tx_start_low:  assert property (tx_load |=> !txd && tx_state_r == asp_pkg::TX_SHIFT)
    else $error("write did not start a frame");
  chk_tx_ninth:      assert property (tx_load && nine |=> tx_sh_r[9] == $past(ctrl_r.tx_ninth_bit))
    else $error("ninth bit not loaded from control");
  chk_tx_stop_done:  assert property (tdone_set |=> txd && tdone_r)
    else $error("transmit done not at stop bit");
  chk_tx_idle_line:  assert property (tx_state_r == asp_pkg::TX_IDLE |-> txd)
    else $error("line not high while idle");
  chk_rx_edge_start: assert property (rx_state_r == asp_pkg::RX_IDLE && !(rx_fall && ctrl_r.rx_allow)
                                      |=> rx_state_r == asp_pkg::RX_IDLE)
    else $error("receiver started without falling edge");
  chk_rx_false_start: assert property (rx_decide && rx_state_r == asp_pkg::RX_START && rx_bit
                                       |=> rx_state_r == asp_pkg::RX_IDLE)
    else $error("false start not abandoned");
  chk_fe_sticky:     assert property (fe_r && !ctrl_wr |=> fe_r)
    else $error("framing error cleared by hardware");
  chk_fe_gate:       assert property (fe_set |-> fcheck_r && !rx_bit ##1 fe_r)
    else $error("framing error outside enabled check");
  chk_rdone_stop:    assert property (rx_done_set && fcheck_r |-> rx_state_r == asp_pkg::RX_STOP ##1 rdone_r)
    else $error("receive done not at stop bit");
  chk_rx_ninth:      assert property (rx_ninth_set |=> rx_ninth_r == $past(rx_bit))
    else $error("ninth flag not stored");
  chk_fixed_rate:    assert property (mode == asp_pkg::MODE_9FIX && rdouble_r |-> rx_tick && tx_tick)
    else $error("fixed rate tick missing");
endmodule

// ==== test/asp_remote_uart.sv ====
// far-side serial transceiver: drives the receive line and captures the transmit line
`timescale 1ns/1ns
module asp_remote_uart (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  // line idles high between frames, as any async transmitter leaves it
  initial rxd = 1'b1;

  // one frame, lsb first; a low stop bit is only sent on purpose
  task automatic send(input logic [7:0] d, input bit nin, input logic ninth, input logic stop, input int bitc);
    logic [10:0] f;
    f = nin ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int k = 0; k < (nin ? 11 : 10); k++) begin
      rxd <= f[k];
      repeat (bitc) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask

  // short low pulse that a receiver must not take for a start bit
  task automatic glitch(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge pclk);
    rxd <= 1'b1;
  endtask

  // waits for a start edge, then samples mid-bit; returns at mid stop bit
  task automatic recv(input bit nin, input int bitc, output logic [10:0] bits);
    int n;
    n = 0;
    bits = 11'h000;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    repeat (bitc / 2) @(posedge pclk);
    for (int k = 0; k < (nin ? 11 : 10); k++) begin
      if (k > 0) repeat (bitc) @(posedge pclk);
      bits[k] = txd;
    end
  endtask
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the asynchronous serial port
`timescale 1ns/1ns
`include "asp_params.svh"
module testbench;
  localparam int TIMEOUT_CYC = 40000; // all frames together need far fewer cycles
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timer1_ovf;
  logic        rxd;
  logic        txd;
  int          error_cnt;
  int          checks;
  int          cyc;

  asp_serial_port u_asp_serial_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer1_ovf(timer1_ovf), .rxd(rxd), .txd(txd));
  asp_remote_uart u_asp_remote_uart (.pclk(pclk), .txd(txd), .rxd(rxd));

  // clock at 8 ns
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // timer 1 stand-in: one-cycle overflow pulse every second clock
  always @(posedge pclk) begin
    timer1_ovf <= ~timer1_ovf;
  end

  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == TIMEOUT_CYC) begin
      error_cnt++;
      $display("[FAIL] %0t run timed out", $time);
      print_verdict;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one apb transfer; a spare edge after release keeps back-to-back calls clean
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                          output logic [31:0] rdata, output logic err);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb_xfer(1'b1, a, {24'h00_0000, d}, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    apb_xfer(1'b0, a, 32'h0000_0000, r, e);
    check(r, {24'h00_0000, exp}, what);
  endtask

  // check off first so control bit 7 lands on the mode, then arm the check
  task automatic setup(input logic [7:0] ctl, input logic [7:0] rate, input logic [7:0] pwr);
    wr(`ASP_OFF_POWER, 8'h00);
    wr(`ASP_OFF_CTRL, ctl);
    wr(`ASP_OFF_RELOAD, 8'hFF);
    wr(`ASP_OFF_RATE, rate);
    repeat (300) @(posedge pclk); // generator count starts at zero after reset and needs ~255 steps to reach reload
    wr(`ASP_OFF_POWER, pwr);
  endtask

  task automatic test_reset;
    logic [31:0] r;
    logic        e;
    for (int k = 0; k < 5; k++) rd_chk(12'(k * 4), 8'h00, "reset value");
    apb_xfer(1'b0, 12'h014, 32'h0000_0000, r, e);
    check({31'h0000_0000, e}, 32'h0000_0001, "unmapped error");
    check(r, 32'h0000_0000, "unmapped data");
    wr(`ASP_OFF_CTRL, 8'h10);
    wr(`ASP_OFF_DATA, 8'hF0);
    repeat (64) @(posedge pclk);
    check({31'h0000_0000, txd}, 32'h0000_0001, "shift mode idle");
    rd_chk(`ASP_OFF_CTRL, 8'h10, "shift mode flags");
    $display("test reset done");
  endtask

  // table: fixed rate doubled and plain, 8-bit on generator fast, 9-bit on timer 1, 8-bit on generator slow
  task automatic test_tx;
    logic [7:0]  ctl [5];
    logic [7:0]  rte [5];
    logic [7:0]  pwr [5];
    int          bitc [5];
    logic [10:0] got;
    logic [7:0]  d;
    ctl = '{8'h88, 8'h80, 8'h40, 8'hC8, 8'h40};
    rte = '{8'h00, 8'h00, 8'h1A, 8'h10, 8'h18};
    pwr = '{8'h80, 8'h00, 8'h80, 8'h80, 8'h80};
    bitc = '{16, 32, 16, 32, 96};
    for (int i = 0; i < 5; i++) begin
      d = 8'hA5 ^ {i[3:0], i[3:0]};
      setup(ctl[i], rte[i], pwr[i]);
      fork
        begin
          wr(`ASP_OFF_DATA, d);
          rd_chk(`ASP_OFF_CTRL, ctl[i], "tx done early");
        end
        u_asp_remote_uart.recv(ctl[i][7], bitc[i], got);
      join
      rd_chk(`ASP_OFF_CTRL, ctl[i] | 8'h02, "tx done at stop");
      if (ctl[i][7]) check({21'h00_0000, got}, {21'h00_0000, 1'b1, ctl[i][3], d, 1'b0}, "9-bit frame");
      else check({21'h00_0000, got}, {22'h00_0000, 1'b1, d, 1'b0}, "8-bit frame");
      repeat (bitc[i]) @(posedge pclk);
    end
    $display("test tx done");
  endtask

  task automatic test_rx_fe;
    setup(8'h50, 8'h16, 8'hC0);
    u_asp_remote_uart.send(8'h3C, 1'b0, 1'b0, 1'b1, 16);
    rd_chk(`ASP_OFF_DATA, 8'h3C, "rx byte");
    rd_chk(`ASP_OFF_CTRL, 8'h55, "good stop flags");
    wr(`ASP_OFF_CTRL, 8'h50);
    u_asp_remote_uart.send(8'hC3, 1'b0, 1'b0, 1'b0, 16);
    rd_chk(`ASP_OFF_CTRL, 8'hD1, "bad stop flags");
    wr(`ASP_OFF_CTRL, 8'hD0);
    u_asp_remote_uart.send(8'h96, 1'b0, 1'b0, 1'b1, 16);
    rd_chk(`ASP_OFF_CTRL, 8'hD5, "error sticky");
    wr(`ASP_OFF_CTRL, 8'h50);
    rd_chk(`ASP_OFF_CTRL, 8'h50, "error cleared");
    $display("test rx framing done");
  endtask

  // 9-bit variable: rx on timer 1 at 32 clocks, tx on generator at 16, both at once
  task automatic test_duplex;
    logic [10:0] got;
    logic        nb;
    logic [7:0]  d;
    setup(8'hD8, 8'h1A, 8'h80);
    for (int n = 0; n < 2; n++) begin
      nb = (n == 0);
      d = nb ? 8'h5A : 8'hA5;
      fork
        u_asp_remote_uart.send(d, 1'b1, nb, nb, 32);
        begin
          wr(`ASP_OFF_DATA, 8'h69);
          u_asp_remote_uart.recv(1'b1, 16, got);
        end
      join
      check({21'h00_0000, got}, {21'h00_0000, 1'b1, 1'b1, 8'h69, 1'b0}, "duplex tx");
      rd_chk(`ASP_OFF_DATA, d, "duplex rx");
      rd_chk(`ASP_OFF_CTRL, nb ? 8'hDF : 8'hDB, "ninth bit flag");
      wr(`ASP_OFF_CTRL, 8'hD8);
    end
    wr(`ASP_OFF_POWER, 8'hC0);
    rd_chk(`ASP_OFF_CTRL, 8'h58, "no error while off");
    $display("test duplex done");
  endtask

  // receive done before the stop bit only when the check is off
  task automatic test_rx_timing;
    logic [31:0] r;
    logic        e;
    for (int c = 0; c < 2; c++) begin
      setup(8'h50, 8'h16, (c == 0) ? 8'h80 : 8'hC0);
      fork
        u_asp_remote_uart.send(8'h81, 1'b0, 1'b0, 1'b1, 16);
        begin
          repeat (146) @(posedge pclk);
          apb_xfer(1'b0, `ASP_OFF_CTRL, 32'h0000_0000, r, e);
          check({31'h0000_0000, r[0]}, {31'h0000_0000, c == 0}, "done before stop");
        end
      join
      rd_chk(`ASP_OFF_DATA, 8'h81, "timed byte");
    end
    wr(`ASP_OFF_CTRL, 8'h50);
    u_asp_remote_uart.glitch(4);
    repeat (200) @(posedge pclk);
    rd_chk(`ASP_OFF_CTRL, 8'h50, "false start");
    wr(`ASP_OFF_CTRL, 8'h40);
    u_asp_remote_uart.send(8'h18, 1'b0, 1'b0, 1'b1, 16);
    rd_chk(`ASP_OFF_CTRL, 8'h40, "rx disallowed");
    rd_chk(`ASP_OFF_DATA, 8'h81, "buffer kept");
    $display("test rx timing done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // reset for 12 clocks, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    timer1_ovf = 1'b0;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset;
    test_tx;
    test_rx_fe;
    test_duplex;
    test_rx_timing;
    print_verdict;
  end
endmodule
